// ===== verilog/pcr_pkg.sv
// package for the peripheral control register bank: offsets, reset values, carriers
package pcr_pkg;
  // control nibble offsets
  localparam logic [6:0] ADDR_TABLE_WIDTH  = 7'h07;
  localparam logic [6:0] ADDR_SYNTH_MODE   = 7'h10;
  localparam logic [6:0] ADDR_SYNTH_REF    = 7'h11;
  localparam logic [6:0] ADDR_UNLOCK       = 7'h12;
  localparam logic [6:0] ADDR_TONE         = 7'h14;
  localparam logic [6:0] ADDR_SLOW_CARRY   = 7'h17;
  localparam logic [6:0] ADDR_INTERVAL_CLK = 7'h18;
  localparam logic [6:0] ADDR_SERIAL_CLK   = 7'h1c;
  localparam logic [6:0] ADDR_SERIAL_MODE  = 7'h1d;
  localparam logic [6:0] ADDR_EXT_EDGE     = 7'h1f;
  localparam logic [6:0] ADDR_FREQ_RSVD    = 7'h20;
  localparam logic [6:0] ADDR_GATE_STATE   = 7'h21;
  localparam logic [6:0] ADDR_FREQ_MODE    = 7'h22;
  localparam logic [6:0] ADDR_FREQ_CMD     = 7'h23;
  localparam logic [6:0] ADDR_ANALOG_CHAN  = 7'h24;
  localparam logic [6:0] ADDR_ANALOG_STAT  = 7'h25;
  localparam logic [6:0] ADDR_TIMER_CLK    = 7'h2b;
  localparam logic [6:0] ADDR_TIMER_MODE   = 7'h2c;
  localparam logic [6:0] ADDR_IRQ_ENABLE   = 7'h2f;
  localparam logic [6:0] ADDR_TEST_AREA    = 7'h31;
  localparam logic [6:0] ADDR_SERIAL_IRQ   = 7'h3c;
  localparam logic [6:0] ADDR_INTERVAL_IRQ = 7'h3d;
  localparam logic [6:0] ADDR_TIMER_IRQ    = 7'h3e;
  localparam logic [6:0] ADDR_EXT_IRQ      = 7'h3f;
  localparam logic [6:0] ADDR_DISPLAY      = 7'h40;
  localparam logic [6:0] ADDR_SEGMENT_MUX  = 7'h69;
  localparam logic [6:0] ADDR_PULLDOWN     = 7'h6a;
  localparam logic [6:0] ADDR_DIR_E        = 7'h6b;
  localparam logic [6:0] ADDR_DIR_D        = 7'h6c;
  localparam logic [6:0] ADDR_DIR_C        = 7'h6d;
  localparam logic [6:0] ADDR_DIR_B        = 7'h6e;
  localparam logic [6:0] ADDR_DIR_A        = 7'h6f;
  // reset values and codes
  localparam logic [2:0] REF_CODE_RESET    = 3'h7;
  localparam logic [1:0] TABLE_WIDTH_8BIT  = 2'h1;
  localparam logic [3:0] TABLE_MASK_8BIT   = 4'h3;
  localparam logic [3:0] TABLE_MASK_FULL   = 4'hf;
  localparam logic [3:0] UNDEFINED_READ    = 4'h0;

  // core access to one nibble
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [3:0] wdata;
  } pcr_access_type;

  // hardware set events, one-cycle pulses
  typedef struct packed {
    logic unlock;
    logic slow_carry;
    logic serial_irq;
    logic interval_irq;
    logic timer_irq;
    logic timer_ovf;
  } pcr_event_type;

  // live status from peripherals
  typedef struct packed {
    logic gate_open_status;
    logic conversion_active;
    logic compare_result;
  } pcr_status_type;

  // control fields steering the peripherals
  typedef struct packed {
    logic [1:0] table_width;
    logic [1:0] serial_clk_code;
    logic       serial_pin_choice;
    logic       serial_out_enable;
    logic       serial_run;
    logic       swallow_lsb;
    logic [1:0] synth_band;
    logic [2:0] ref_code;
    logic       tone_pin_select;
    logic [1:0] tone_code;
    logic       interval_rate_bit;
    logic       event_timer_run;
    logic [1:0] event_clk_code;
    logic       gate_close_edge;
    logic       gate_open_edge;
    logic       gate_or_modulo;
    logic       ext_edge_select;
    logic [3:0] irq_en;
    logic [1:0] counter_input;
    logic [1:0] gate_time;
    logic [1:0] analog_chan;
    logic       display_on;
    logic [2:0] segment_pin_select;
    logic [3:0] pulldown_off;
    logic [3:0] dir_e;
    logic [3:0] dir_d;
    logic [3:0] dir_c;
    logic [3:0] dir_b;
    logic [3:0] dir_a;
  } pcr_ctrl_type;

  // flags set by hardware
  typedef struct packed {
    logic unlock_flag;
    logic slow_tick_carry_flag;
    logic serial_irq_flag;
    logic interval_irq_flag;
    logic event_timer_irq_flag;
    logic ext_pin_irq_flag;
    logic event_timer_overflow;
    logic ext_pin_level;
  } pcr_flags_type;
endpackage : pcr_pkg

// ===== verilog/pcr_bank.sv
// peripheral control register bank: nibble-wide control registers of the core
//
// Function
// - two-bit table read width at 07H; 8-bit mode fills only nibbles 0EH, 0FH
// - serial clock code at 1CH: 00 external clock, others internal rates
// - 1DH: bit2 serial pin choice, bit1 port or serial output, bit0 run
// - 11H three-bit reference code, reset and clock stop force 7
// - 12H bit0 unlock flag, cleared by read, kept over clock stop
// - 14H: bit2 tone pin select, bits 1:0 tone output code
// - 17H bit0 slow tick carry, read clears, of the resets only pin reset clears it
// - 18H bit0 interval tick rate select, resets to 0
// - 2BH: bit3 run, bit2 writes clear timer, bits 1:0 clock code
// - 2CH: bit3 overflow flag, bits 2:1 gate edges, bit0 gate/modulo
// - 1FH bit0 external edge select, kept over clock stop
// - 2FH four interrupt enables, reset to 0
// - 3CH-3FH bit0 pending requests; 3FH bit3 shows external pin level
// - 22H: bits 3:2 counter input, bits 1:0 gate time
// - 23H write-only start and clear; 21H bit0 reads gate open
// - 24H two-bit analog channel, resets to 0
// - 25H read-only: bit1 conversion active, bit0 compare result
// - 40H bit0 display on; 69H bits 2:0 segment pin select
// - 6AH pull-down disconnects, 6BH-6FH pin directions, all reset 0
// - write-only or unused reads undefined; read-only or unused writes ignored
// - fixed-zero bits read 0 and ignore writes
`timescale 1ns/1ps

module pcr_bank (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  wdt_sp_reset,
  input  wire logic                  clock_stop,
  input  wire pcr_pkg::pcr_access_type access,
  input  wire pcr_pkg::pcr_event_type  events,
  input  wire pcr_pkg::pcr_status_type status,
  input  wire logic                  ext_pin,
  output logic [3:0]                 rd_data_r,
  output pcr_pkg::pcr_ctrl_type      ctrl_r,
  output pcr_pkg::pcr_flags_type     flags_r,
  output logic [3:0]                 table_nibble_mask_r,
  output logic                       counter_go_r,
  output logic                       counter_clear_r,
  output logic                       event_timer_clear_r
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    pcr_pkg::pcr_ctrl_type  ctrl;
    pcr_pkg::pcr_flags_type flags;
    logic [3:0]             rd_data;
    logic [3:0]             table_mask;
    logic                   counter_go;
    logic                   counter_clear;
    logic                   timer_clear;
    logic                   ext_s1;
    logic                   ext_s2;
    logic                   ext_s3;
  } pcr_state_type;

  // pin reset image: reference code 7, undefined bits taken as 0
  localparam pcr_state_type ST_RESET = '{
    ctrl:       '{ref_code: pcr_pkg::REF_CODE_RESET, default: '0},
    table_mask: pcr_pkg::TABLE_MASK_FULL,
    default:    '0
  };

  pcr_state_type st_r;
  pcr_state_type st_nxt;

  // address match used by the read-clear paths
  function automatic logic hit(input pcr_pkg::pcr_access_type a, input logic [6:0] off);
    hit = (a.addr == off);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic       lvl_ok;
    logic       rise;
    logic       fall;
    logic       ext_evt;
    logic [3:0] w;
    lvl_ok = 1'b0;
    rise   = 1'b0;
    fall   = 1'b0;
    ext_evt = 1'b0;
    w      = access.wdata;
    st_nxt = st_r;
    st_nxt.counter_go    = 1'b0;
    st_nxt.counter_clear = 1'b0;
    st_nxt.timer_clear   = 1'b0;

    // external pin: three flops, level moves once second and third agree
    st_nxt.ext_s1 = ext_pin;
    st_nxt.ext_s2 = st_r.ext_s1;
    st_nxt.ext_s3 = st_r.ext_s2;
    lvl_ok = (st_r.ext_s2 == st_r.ext_s3);
    rise   = lvl_ok && st_r.ext_s2 && !st_r.flags.ext_pin_level;
    fall   = lvl_ok && !st_r.ext_s2 && st_r.flags.ext_pin_level;
    if (lvl_ok) begin
      st_nxt.flags.ext_pin_level = st_r.ext_s2;
    end
    ext_evt = st_r.ctrl.ext_edge_select ? fall : rise;

    // register read, registered one cycle later
    st_nxt.rd_data = pcr_pkg::UNDEFINED_READ;
    if (access.rd) begin
      case (access.addr)
        pcr_pkg::ADDR_TABLE_WIDTH:  st_nxt.rd_data = {2'b00, st_r.ctrl.table_width};
        pcr_pkg::ADDR_SYNTH_MODE:   st_nxt.rd_data = {st_r.ctrl.swallow_lsb, 1'b0,
                                                      st_r.ctrl.synth_band};
        pcr_pkg::ADDR_SYNTH_REF:    st_nxt.rd_data = {1'b0, st_r.ctrl.ref_code};
        pcr_pkg::ADDR_UNLOCK:       st_nxt.rd_data = {3'b000, st_r.flags.unlock_flag};
        pcr_pkg::ADDR_TONE:         st_nxt.rd_data = {1'b0, st_r.ctrl.tone_pin_select,
                                                      st_r.ctrl.tone_code};
        pcr_pkg::ADDR_SLOW_CARRY:   st_nxt.rd_data = {3'b000,
                                                      st_r.flags.slow_tick_carry_flag};
        pcr_pkg::ADDR_INTERVAL_CLK: st_nxt.rd_data = {3'b000, st_r.ctrl.interval_rate_bit};
        pcr_pkg::ADDR_SERIAL_CLK:   st_nxt.rd_data = {2'b00, st_r.ctrl.serial_clk_code};
        pcr_pkg::ADDR_SERIAL_MODE:  st_nxt.rd_data = {1'b0, st_r.ctrl.serial_pin_choice,
                                                      st_r.ctrl.serial_out_enable,
                                                      st_r.ctrl.serial_run};
        pcr_pkg::ADDR_EXT_EDGE:     st_nxt.rd_data = {3'b000, st_r.ctrl.ext_edge_select};
        pcr_pkg::ADDR_GATE_STATE:   st_nxt.rd_data = {3'b000, status.gate_open_status};
        pcr_pkg::ADDR_FREQ_MODE:    st_nxt.rd_data = {st_r.ctrl.counter_input,
                                                      st_r.ctrl.gate_time};
        pcr_pkg::ADDR_ANALOG_CHAN:  st_nxt.rd_data = {2'b00, st_r.ctrl.analog_chan};
        pcr_pkg::ADDR_ANALOG_STAT:  st_nxt.rd_data = {2'b00, status.conversion_active,
                                                      status.compare_result};
        pcr_pkg::ADDR_TIMER_CLK:    st_nxt.rd_data = {st_r.ctrl.event_timer_run, 1'b0,
                                                      st_r.ctrl.event_clk_code};
        pcr_pkg::ADDR_TIMER_MODE:   st_nxt.rd_data = {st_r.flags.event_timer_overflow,
                                                      st_r.ctrl.gate_close_edge,
                                                      st_r.ctrl.gate_open_edge,
                                                      st_r.ctrl.gate_or_modulo};
        pcr_pkg::ADDR_IRQ_ENABLE:   st_nxt.rd_data = st_r.ctrl.irq_en;
        pcr_pkg::ADDR_SERIAL_IRQ:   st_nxt.rd_data = {3'b000, st_r.flags.serial_irq_flag};
        pcr_pkg::ADDR_INTERVAL_IRQ: st_nxt.rd_data = {3'b000, st_r.flags.interval_irq_flag};
        pcr_pkg::ADDR_TIMER_IRQ:    st_nxt.rd_data = {3'b000,
                                                      st_r.flags.event_timer_irq_flag};
        pcr_pkg::ADDR_EXT_IRQ:      st_nxt.rd_data = {st_r.flags.ext_pin_level, 2'b00,
                                                      st_r.flags.ext_pin_irq_flag};
        pcr_pkg::ADDR_DISPLAY:      st_nxt.rd_data = {3'b000, st_r.ctrl.display_on};
        pcr_pkg::ADDR_SEGMENT_MUX:  st_nxt.rd_data = {1'b0, st_r.ctrl.segment_pin_select};
        pcr_pkg::ADDR_PULLDOWN:     st_nxt.rd_data = st_r.ctrl.pulldown_off;
        pcr_pkg::ADDR_DIR_E:        st_nxt.rd_data = st_r.ctrl.dir_e;
        pcr_pkg::ADDR_DIR_D:        st_nxt.rd_data = st_r.ctrl.dir_d;
        pcr_pkg::ADDR_DIR_C:        st_nxt.rd_data = st_r.ctrl.dir_c;
        pcr_pkg::ADDR_DIR_B:        st_nxt.rd_data = st_r.ctrl.dir_b;
        pcr_pkg::ADDR_DIR_A:        st_nxt.rd_data = st_r.ctrl.dir_a;
        default:                    st_nxt.rd_data = pcr_pkg::UNDEFINED_READ;
      endcase
    end

    // read-and-reset flags
    if (access.rd && hit(access, pcr_pkg::ADDR_UNLOCK)) begin
      st_nxt.flags.unlock_flag = 1'b0;
    end
    if (access.rd && hit(access, pcr_pkg::ADDR_SLOW_CARRY)) begin
      st_nxt.flags.slow_tick_carry_flag = 1'b0;
    end

    // writes; fixed-zero, read-only and unused stay untouched, write-only 23H gives pulses
    if (access.wr) begin
      case (access.addr)
        pcr_pkg::ADDR_TABLE_WIDTH:  st_nxt.ctrl.table_width = w[1:0];
        pcr_pkg::ADDR_SYNTH_MODE: begin
          st_nxt.ctrl.swallow_lsb = w[3];
          st_nxt.ctrl.synth_band  = w[1:0];
        end
        pcr_pkg::ADDR_SYNTH_REF:    st_nxt.ctrl.ref_code = w[2:0];
        pcr_pkg::ADDR_TONE: begin
          st_nxt.ctrl.tone_pin_select = w[2];
          st_nxt.ctrl.tone_code       = w[1:0];
        end
        pcr_pkg::ADDR_INTERVAL_CLK: st_nxt.ctrl.interval_rate_bit = w[0];
        pcr_pkg::ADDR_SERIAL_CLK:   st_nxt.ctrl.serial_clk_code = w[1:0];
        pcr_pkg::ADDR_SERIAL_MODE: begin
          st_nxt.ctrl.serial_pin_choice = w[2];
          st_nxt.ctrl.serial_out_enable = w[1];
          st_nxt.ctrl.serial_run        = w[0];
        end
        pcr_pkg::ADDR_EXT_EDGE:     st_nxt.ctrl.ext_edge_select = w[0];
        pcr_pkg::ADDR_FREQ_MODE: begin
          st_nxt.ctrl.counter_input = w[3:2];
          st_nxt.ctrl.gate_time     = w[1:0];
        end
        pcr_pkg::ADDR_FREQ_CMD: begin
          st_nxt.counter_go    = w[1];
          st_nxt.counter_clear = w[0];
        end
        pcr_pkg::ADDR_ANALOG_CHAN:  st_nxt.ctrl.analog_chan = w[1:0];
        pcr_pkg::ADDR_TIMER_CLK: begin
          st_nxt.ctrl.event_timer_run = w[3];
          st_nxt.timer_clear          = w[2];
          st_nxt.ctrl.event_clk_code  = w[1:0];
        end
        pcr_pkg::ADDR_TIMER_MODE: begin
          st_nxt.flags.event_timer_overflow = w[3];
          st_nxt.ctrl.gate_close_edge       = w[2];
          st_nxt.ctrl.gate_open_edge        = w[1];
          st_nxt.ctrl.gate_or_modulo        = w[0];
        end
        pcr_pkg::ADDR_IRQ_ENABLE:   st_nxt.ctrl.irq_en = w;
        pcr_pkg::ADDR_SERIAL_IRQ:   st_nxt.flags.serial_irq_flag = w[0];
        pcr_pkg::ADDR_INTERVAL_IRQ: st_nxt.flags.interval_irq_flag = w[0];
        pcr_pkg::ADDR_TIMER_IRQ:    st_nxt.flags.event_timer_irq_flag = w[0];
        pcr_pkg::ADDR_EXT_IRQ:      st_nxt.flags.ext_pin_irq_flag = w[0];
        // test bit 3 is never stored, so a stray write cannot enter test mode
        pcr_pkg::ADDR_DISPLAY:      st_nxt.ctrl.display_on = w[0];
        pcr_pkg::ADDR_SEGMENT_MUX:  st_nxt.ctrl.segment_pin_select = w[2:0];
        pcr_pkg::ADDR_PULLDOWN:     st_nxt.ctrl.pulldown_off = w;
        pcr_pkg::ADDR_DIR_E:        st_nxt.ctrl.dir_e = w;
        pcr_pkg::ADDR_DIR_D:        st_nxt.ctrl.dir_d = w;
        pcr_pkg::ADDR_DIR_C:        st_nxt.ctrl.dir_c = w;
        pcr_pkg::ADDR_DIR_B:        st_nxt.ctrl.dir_b = w;
        pcr_pkg::ADDR_DIR_A:        st_nxt.ctrl.dir_a = w;
        // test areas 20H and 31H fall here and are simply dropped
        default:                    st_nxt = st_nxt;
      endcase
    end

    // hardware sets follow the read and write paths so they win over clearing reads and writes
    if (events.unlock)       st_nxt.flags.unlock_flag          = 1'b1;
    if (events.slow_carry)   st_nxt.flags.slow_tick_carry_flag = 1'b1;
    if (events.serial_irq)   st_nxt.flags.serial_irq_flag      = 1'b1;
    if (events.interval_irq) st_nxt.flags.interval_irq_flag    = 1'b1;
    if (events.timer_irq)    st_nxt.flags.event_timer_irq_flag = 1'b1;
    if (events.timer_ovf)    st_nxt.flags.event_timer_overflow = 1'b1;
    if (ext_evt)             st_nxt.flags.ext_pin_irq_flag     = 1'b1;

    // clock stop: fields without retention go to their stop values
    if (clock_stop) begin
      st_nxt.ctrl.serial_clk_code    = '0;
      st_nxt.ctrl.serial_pin_choice  = 1'b0;
      st_nxt.ctrl.serial_out_enable  = 1'b0;
      st_nxt.ctrl.serial_run         = 1'b0;
      st_nxt.ctrl.synth_band         = '0;
      st_nxt.ctrl.ref_code           = pcr_pkg::REF_CODE_RESET;
      st_nxt.ctrl.tone_pin_select    = 1'b0;
      st_nxt.ctrl.tone_code          = '0;
      st_nxt.ctrl.event_timer_run    = 1'b0;
      st_nxt.ctrl.event_clk_code     = '0;
      st_nxt.flags.event_timer_overflow = 1'b0;
      st_nxt.ctrl.gate_close_edge    = 1'b0;
      st_nxt.ctrl.gate_open_edge     = 1'b0;
      st_nxt.ctrl.gate_or_modulo     = 1'b0;
      st_nxt.ctrl.counter_input      = '0;
      st_nxt.ctrl.gate_time          = '0;
      st_nxt.counter_go              = 1'b0;
      st_nxt.counter_clear           = 1'b0;
      st_nxt.timer_clear             = 1'b0;
      st_nxt.ctrl.display_on         = 1'b0;
      st_nxt.ctrl.segment_pin_select = '0;
    end

    // watchdog/stack reset: pin reset image except carry, unlock, pin level, swallow_lsb and the pin synchronizer
    if (wdt_sp_reset) begin
      st_nxt = ST_RESET;
      st_nxt.flags.slow_tick_carry_flag = st_r.flags.slow_tick_carry_flag;
      st_nxt.flags.unlock_flag          = st_r.flags.unlock_flag;
      st_nxt.flags.ext_pin_level        = st_r.flags.ext_pin_level;
      st_nxt.ctrl.swallow_lsb           = st_r.ctrl.swallow_lsb;
      st_nxt.ext_s1                     = ext_pin;
      st_nxt.ext_s2                     = st_r.ext_s1;
      st_nxt.ext_s3                     = st_r.ext_s2;
    end

    // nibbles that a table read fills, from the width selection
    st_nxt.table_mask = (st_nxt.ctrl.table_width == pcr_pkg::TABLE_WIDTH_8BIT) ?
                        pcr_pkg::TABLE_MASK_8BIT : pcr_pkg::TABLE_MASK_FULL;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register, synchronous pin reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state flops
  assign rd_data_r           = st_r.rd_data;
  assign ctrl_r              = st_r.ctrl;
  assign flags_r             = st_r.flags;
  assign table_nibble_mask_r = st_r.table_mask;
  assign counter_go_r        = st_r.counter_go;
  assign counter_clear_r     = st_r.counter_clear;
  assign event_timer_clear_r = st_r.timer_clear;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic quiet;
  assign quiet = !wdt_sp_reset && !clock_stop;

  property p_ref_reset;
    wdt_sp_reset |=> ctrl_r.ref_code == pcr_pkg::REF_CODE_RESET;
  endproperty
  a_ref_reset: assert property (p_ref_reset) else $error("ref code not 7 after reset");

  property p_unlock_clear;
    access.rd && access.addr == pcr_pkg::ADDR_UNLOCK && !events.unlock && quiet
      |=> !flags_r.unlock_flag && rd_data_r[0] == $past(flags_r.unlock_flag);
  endproperty
  a_unlock_clear: assert property (p_unlock_clear) else $error("unlock read-clear");

  property p_set_wins;
    events.unlock && !wdt_sp_reset |=> flags_r.unlock_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("unlock event lost");

  property p_carry_kept;
    wdt_sp_reset && !events.slow_carry && !access.rd
      |=> flags_r.slow_tick_carry_flag == $past(flags_r.slow_tick_carry_flag);
  endproperty
  a_carry_kept: assert property (p_carry_kept) else $error("carry lost on wdt");

  property p_counter_go;
    access.wr && access.addr == pcr_pkg::ADDR_FREQ_CMD && access.wdata[1] && quiet
      ##1 !(access.wr && access.addr == pcr_pkg::ADDR_FREQ_CMD && access.wdata[1])
      |-> counter_go_r ##1 !counter_go_r;
  endproperty
  a_counter_go: assert property (p_counter_go) else $error("counter go pulse wrong");

  property p_ro_write;
    access.wr && access.addr == pcr_pkg::ADDR_GATE_STATE && quiet |=> $stable(ctrl_r);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_fixed_zero;
    access.rd && access.addr == pcr_pkg::ADDR_SERIAL_CLK |=> rd_data_r[3:2] == 2'b00;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("fixed bits not zero");

  property p_dir_write;
    access.wr && access.addr == pcr_pkg::ADDR_DIR_A && !wdt_sp_reset
      |=> ctrl_r.dir_a == $past(access.wdata);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write lost");

  property p_table_mask;
    ctrl_r.table_width == pcr_pkg::TABLE_WIDTH_8BIT |-> table_nibble_mask_r == pcr_pkg::TABLE_MASK_8BIT;
  endproperty
  a_table_mask: assert property (p_table_mask) else $error("table mask wrong");

  property p_ext_rise;
    $rose(flags_r.ext_pin_level) && !$past(ctrl_r.ext_edge_select) && !$past(wdt_sp_reset)
      |-> flags_r.ext_pin_irq_flag;
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("rising edge request missing");

  // reset also drops the level, so only a fall seen out of reset counts
  property p_ext_fall;
    $fell(flags_r.ext_pin_level) && $past(ctrl_r.ext_edge_select) && !$past(wdt_sp_reset)
      && $past(resetn) |-> flags_r.ext_pin_irq_flag;
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("falling edge request missing");

  c_unlock_read: cover property (access.rd && access.addr == 7'h12 && flags_r.unlock_flag);
  c_ext_irq: cover property ($rose(flags_r.ext_pin_irq_flag));
  c_clock_stop: cover property (clock_stop ##1 ctrl_r.ref_code == 3'h7);
  c_ext_fall: cover property ($fell(flags_r.ext_pin_level) && flags_r.ext_pin_irq_flag);

endmodule : pcr_bank

// ===== test/pcr_bank_tb_top.sv
// self-checking bench for the peripheral control register bank
`timescale 1ns/1ps
module pcr_bank_tb_top;
  logic                    clk = 0, resetn = 0, wdt = 0, cstop = 0, pin = 0, rd_d = 0;
  pcr_pkg::pcr_access_type acc = '0;
  pcr_pkg::pcr_event_type  ev = '0;
  pcr_pkg::pcr_status_type st = '0;
  pcr_pkg::pcr_ctrl_type   ctrl;
  pcr_pkg::pcr_flags_type  flags;
  logic [3:0]              rdata, mask;
  logic                    go, clr, tclr;
  logic [3:0]              expq[$];
  logic [2:0]              pq[$];
  logic [31:0]             seed = 32'h2071_c76a;
  int                      bad_count = 0, checks = 0, cyc = 0;
  // read-write nibbles and the bits that survive a write
  logic [6:0] adr[20] = '{7'h07, 7'h1c, 7'h1d, 7'h10, 7'h11, 7'h14, 7'h18, 7'h1f, 7'h2f,
    7'h22, 7'h24, 7'h2b, 7'h2c, 7'h3c, 7'h3d, 7'h3e, 7'h40, 7'h69, 7'h6a, 7'h6f};
  logic [3:0] msk[20] = '{4'h3, 4'h3, 4'h7, 4'hb, 4'h7, 4'h7, 4'h1, 4'h1, 4'hf, 4'hf,
    4'h3, 4'hb, 4'hf, 4'h1, 4'h1, 4'h1, 4'h1, 4'h7, 4'hf, 4'hf};

  pcr_bank dut (.clk(clk), .resetn(resetn), .wdt_sp_reset(wdt), .clock_stop(cstop),
    .access(acc), .events(ev), .status(st), .ext_pin(pin), .rd_data_r(rdata),
    .ctrl_r(ctrl), .flags_r(flags), .table_nibble_mask_r(mask),
    .counter_go_r(go), .counter_clear_r(clr), .event_timer_clear_r(tclr));

  //////////////////////////////////////////////////////////////////////////////
  // free-running clock
  initial forever #5 clk = ~clk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // strobe stays up across back-to-back calls, so acc is assigned once per step
  task automatic bus(input logic w, input logic r, input logic [6:0] a,
                     input logic [3:0] d, input logic [3:0] e);
    if (r) expq.push_back(e);
    // command pulses expected one cycle after the write: {go, clear, timer clear}
    if (w && a == 7'h23 && d[1:0] != 2'b00) pq.push_back({d[1], d[0], 1'b0});
    if (w && a == 7'h2b && d[2]) pq.push_back(3'b001);
    acc <= '{w, r, a, d};
    @(posedge clk);
  endtask : bus

  task automatic idle(input int n);
    acc <= '0;
    repeat (n) @(posedge clk);
  endtask : idle

  // read data lands one cycle after the strobe; compare mid-cycle
  always @(posedge clk) rd_d <= acc.rd;
  always @(negedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      bad_count++;
      summarize();
    end
    if (rd_d) chk("rd_data", rdata, expq.pop_front());
    if (go || clr || tclr)
      chk("pulses", {1'b0, go, clr, tclr}, {1'b0, pq.pop_front()});
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    bus(0, 1, 7'h11, '0, 4'h7);
    bus(0, 1, 7'h6b, '0, 4'h0);
    // random writes, never bit3 of 40H, read back through fixed-zero masks
    foreach (adr[i]) begin
      seed = xs(seed);
      bus(1, 0, adr[i], seed[3:0] & ((adr[i] == 7'h40) ? 4'h7 : 4'hf), '0);
      bus(0, 1, adr[i], '0, seed[3:0] & msk[i]);
    end
    bus(1, 0, 7'h07, 4'h1, '0);
    idle(1);
    chk("table_mask", mask, 4'h3);
    st <= '{1'b1, 1'b1, 1'b0};
    bus(1, 0, 7'h25, 4'hf, '0);
    bus(1, 0, 7'h30, 4'hf, '0);
    bus(1, 0, 7'h21, 4'hf, '0);
    bus(0, 1, 7'h25, '0, 4'h2);
    bus(0, 1, 7'h21, '0, 4'h1);
    bus(0, 1, 7'h23, '0, 4'h0);
    bus(0, 1, 7'h30, '0, 4'h0);
    bus(1, 0, 7'h23, 4'h3, '0);
    bus(1, 0, 7'h2b, 4'h4, '0);
    chk("go_clear", {2'b00, go, clr}, 4'h3);
    idle(1);
    chk("timer_clear", {3'b000, tclr}, 4'h1);
    // set pulse coincides with the clearing read: flag must survive
    ev <= 6'h30;
    bus(0, 1, 7'h12, '0, 4'h0);
    ev <= '0;
    bus(0, 1, 7'h12, '0, 4'h1);
    bus(0, 1, 7'h12, '0, 4'h0);
    bus(0, 1, 7'h17, '0, 4'h1);
    ev <= 6'h10;
    idle(1);
    ev <= '0;
    wdt <= 1;
    idle(1);
    wdt <= 0;
    bus(0, 1, 7'h17, '0, 4'h1);
    bus(0, 1, 7'h11, '0, 4'h7);
    bus(0, 1, 7'h2f, '0, 4'h0);
    bus(1, 0, 7'h1f, 4'h1, '0);
    bus(1, 0, 7'h11, 4'h2, '0);
    cstop <= 1;
    idle(1);
    cstop <= 0;
    bus(0, 1, 7'h11, '0, 4'h7);
    bus(0, 1, 7'h1f, '0, 4'h1);
    // falling edge chosen: rising pin shows level only, falling raises request
    pin <= 1;
    idle(6);
    bus(0, 1, 7'h3f, '0, 4'h8);
    pin <= 0;
    idle(6);
    bus(0, 1, 7'h3f, '0, 4'h1);
    // rising edge chosen, request cleared: a rising pin now raises it again
    bus(1, 0, 7'h1f, 4'h0, '0);
    bus(1, 0, 7'h3f, 4'h0, '0);
    pin <= 1;
    idle(6);
    bus(0, 1, 7'h3f, '0, 4'h9);
    idle(3);
    summarize();
  end
endmodule : pcr_bank_tb_top
